// [design/encoder_addl_data.sv]
`timescale 1ns/1ps
`default_nettype none
module encoder_addl_data #(
    parameter int ACCESS_WAIT = enc_addl_pkg::ACCESS_CYCLES,
    parameter bit ABSOLUTE = 1'b0,
    parameter logic [15:0] ENC_TYPE = enc_addl_pkg::incremental_rotary_type
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic linkClk,
    input wire logic selValid,
    input wire logic [7:0] memory_range_select_code,
    input wire logic accValid,
    input wire logic accWrite,
    input wire logic [5:0] accAddr,
    input wire logic [15:0] accData,
    input wire logic [23:0] pos2Abs,
    input wire logic [23:0] sensorValue,
    input wire logic [15:0] errorSources,
    input wire logic referenceIn,
    input wire logic initDone,
    output logic busy,
    output logic [15:0] readData,
    output logic readValid,
    output logic [enc_addl_pkg::ADDL_WORD_BITS-1:0] addlWord,
    output logic addlWordValid,
    output logic [3:0] sensorAddr,
    output logic reference_done_bit,
    output logic [1:0] protectStatus,
    output logic initPulse
);
    initial begin
        if (ACCESS_WAIT < 2) $error("ACCESS_WAIT must be at least 2");
    end

    typedef enum logic [1:0] {
        IDLE = 2'b00,
        WAIT = 2'b01,
        DONE = 2'b10
    } acc_state_type;

    typedef struct packed {
        logic [1:0] sync;
        logic prevLink;
        logic [7:0] rangeSel;
        logic [1:0] area;
        acc_state_type accState;
        logic [31:0] cnt;
        logic wr;
        logic [5:0] addr;
        logic [15:0] data;
        logic busy;
        logic [15:0] rdata;
        logic rvalid;
        logic [29:0] word;
        logic wvalid;
        logic [3:0] sens;
        logic [23:0] relPos;
        logic refDone;
        logic [1:0] prot;
        logic init;
    } state_type;

    state_type s, next_s;
    logic [15:0] memRd;
    logic memWe;
    logic [7:0] memAddr;

    param_memory #(.ADDR_BITS(8), .DATA_BITS(16)) u_mem (
        .mclk(mclk),
        .writeEn(memWe),
        .addr(memAddr),
        .writeData(s.data),
        .readData(memRd)
    );

    function automatic logic [4:0] crc5(input logic [28:0] d);
        logic [4:0] c;
        c = 5'h1f;
        for (int i = 28; i >= 0; i--) begin
            c = {c[3:0], 1'b0} ^ ((c[4] ^ d[i]) ? enc_addl_pkg::CRC_POLY : 5'h00);
        end
        return c;
    endfunction

    function automatic logic [1:0] area_of(input logic [7:0] code);
        case (code)
            enc_addl_pkg::SEL_OEM: area_of = enc_addl_pkg::AREA_OEM;
            enc_addl_pkg::SEL_OPPARAM: area_of = enc_addl_pkg::AREA_OPPARAM;
            enc_addl_pkg::SEL_OPSTATUS: area_of = enc_addl_pkg::AREA_OPSTATUS;
            default: area_of = enc_addl_pkg::AREA_MANUF;
        endcase
    endfunction

    logic linkRise;
    logic protHit;
    logic [4:0] cid;
    logic [23:0] payload;
    logic [28:0] body;

    always_comb begin
        // synchroniser holds the inverted link level so reset matches the idle high link
        linkRise = ~s.sync[1] & s.prevLink;
        protHit = (s.area == enc_addl_pkg::AREA_MANUF)
            || (s.area == enc_addl_pkg::AREA_OEM && s.prot[enc_addl_pkg::PROT_OEM_BIT])
            || (s.area == enc_addl_pkg::AREA_OPPARAM
                && s.prot[enc_addl_pkg::PROT_OPPARAM_BIT]);
        memAddr = {s.area, s.addr};
        memWe = (s.accState == DONE) && s.wr && !protHit
            && (s.area != enc_addl_pkg::AREA_OPSTATUS);
        cid = enc_addl_pkg::ID_NONE;
        payload = 24'h000000;
        unique case (s.rangeSel)
            enc_addl_pkg::SEL_POS2: begin
                cid = enc_addl_pkg::ID_POS2;
                payload = ABSOLUTE ? pos2Abs : (s.refDone ? pos2Abs : s.relPos);
            end
            enc_addl_pkg::SEL_SENSOR: begin
                cid = enc_addl_pkg::ID_SENSOR;
                payload = {s.sens, sensorValue[19:0]};
            end
            enc_addl_pkg::SEL_ACK: begin
                cid = enc_addl_pkg::ID_ACK;
                payload = {16'h0000, s.rangeSel};
            end
            enc_addl_pkg::SEL_ERRSRC: begin
                cid = enc_addl_pkg::ID_ERRSRC;
                payload = {8'h00, errorSources};
            end
            enc_addl_pkg::SEL_DESELECT: begin
                cid = enc_addl_pkg::ID_NONE;
            end
            default: begin
                cid = enc_addl_pkg::ID_PARAM;
                payload = {2'b00, s.addr, s.rdata};
            end
        endcase
        body = {cid, payload};
        next_s = s;
        next_s.sync = {s.sync[0], ~linkClk};
        next_s.prevLink = s.sync[1];
        next_s.rvalid = 1'b0;
        next_s.wvalid = 1'b0;
        next_s.init = 1'b0;
        if (referenceIn || ABSOLUTE) begin
            next_s.refDone = 1'b1;
        end
        if (selValid) begin
            next_s.rangeSel = memory_range_select_code;
            if (memory_range_select_code == enc_addl_pkg::SEL_MANUF
                || memory_range_select_code == enc_addl_pkg::SEL_OEM
                || memory_range_select_code == enc_addl_pkg::SEL_OPPARAM
                || memory_range_select_code == enc_addl_pkg::SEL_OPSTATUS) begin
                next_s.area = area_of(memory_range_select_code);
            end
        end
        if (linkRise) begin
            next_s.relPos = s.relPos + 24'h000001;
            if (s.rangeSel != enc_addl_pkg::SEL_DESELECT) begin
                next_s.word = {1'b0, body} ^ {25'h0000000, crc5(body)};
                next_s.wvalid = 1'b1;
                if (s.rangeSel == enc_addl_pkg::SEL_SENSOR) begin
                    next_s.sens = s.sens + 4'h1;
                end
            end
        end
        unique case (s.accState)
            IDLE: begin
                if (accValid) begin
                    next_s.accState = WAIT;
                    next_s.busy = 1'b1;
                    next_s.cnt = 32'h00000000;
                    next_s.wr = accWrite;
                    next_s.addr = accAddr;
                    next_s.data = accData;
                end
            end
            WAIT: begin
                next_s.cnt = s.cnt + 32'h00000001;
                if (s.cnt >= 32'(ACCESS_WAIT - 2)) begin
                    next_s.accState = DONE;
                end
            end
            DONE: begin
                next_s.accState = IDLE;
                next_s.busy = 1'b0;
                next_s.rvalid = !s.wr;
                if (s.area == enc_addl_pkg::AREA_OPSTATUS) begin
                    if (s.wr && s.addr == enc_addl_pkg::WORD_PROTECT) begin
                        next_s.prot = s.prot | s.data[1:0];
                        next_s.init = s.data[2];
                    end
                    next_s.rdata = (s.addr == enc_addl_pkg::WORD_ERRSRC) ? errorSources
                        : {14'h0000, s.prot};
                end else if (s.area == enc_addl_pkg::AREA_MANUF
                    && s.addr == enc_addl_pkg::WORD_TYPE) begin
                    next_s.rdata = ENC_TYPE;
                end else begin
                    next_s.rdata = memRd;
                end
            end
            default: begin
                next_s.accState = IDLE;
                next_s.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy = s.busy;
    assign readData = s.rdata;
    assign readValid = s.rvalid;
    assign addlWord = s.word;
    assign addlWordValid = s.wvalid;
    assign sensorAddr = s.sens;
    assign reference_done_bit = s.refDone;
    assign protectStatus = s.prot;
    assign initPulse = s.init;

    property p_busy_rise;
        @(posedge mclk) disable iff (!resetn)
        (s.accState == IDLE && accValid) |=> busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");

    property p_busy_fall;
        @(posedge mclk) disable iff (!resetn)
        (s.accState == DONE) |=> !busy;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy not released");

    property p_prot_sticky;
        @(posedge mclk) disable iff (!resetn)
        $past(protectStatus[0]) |-> protectStatus[0];
    endproperty
    a_prot_sticky: assert property (p_prot_sticky) else $error("protection cleared");

    property p_manuf_wp;
        @(posedge mclk) disable iff (!resetn)
        (s.area == enc_addl_pkg::AREA_MANUF) |-> !memWe;
    endproperty
    a_manuf_wp: assert property (p_manuf_wp) else $error("manufacturer write");

    property p_first_low;
        @(posedge mclk) disable iff (!resetn)
        addlWordValid |-> !addlWord[29];
    endproperty
    a_first_low: assert property (p_first_low) else $error("first bit high");

    property p_sensor_roll;
        @(posedge mclk) disable iff (!resetn)
        (addlWordValid && $past(s.rangeSel) == enc_addl_pkg::SEL_SENSOR)
            |-> sensorAddr == $past(sensorAddr) + 4'h1;
    endproperty
    a_sensor_roll: assert property (p_sensor_roll) else $error("sensor not rolled");

    property p_abs_ref;
        @(posedge mclk) disable iff (!resetn)
        ABSOLUTE |-> ##1 reference_done_bit;
    endproperty
    a_abs_ref: assert property (p_abs_ref) else $error("reference low");

    property p_deselect_silent;
        @(posedge mclk) disable iff (!resetn)
        (s.rangeSel == enc_addl_pkg::SEL_DESELECT) |=> !addlWordValid;
    endproperty
    a_deselect_silent: assert property (p_deselect_silent) else $error("word unselected");
endmodule
`default_nettype wire

// [design/enc_addl_pkg.sv]
package enc_addl_pkg;
    // additional data word layout
    localparam int ADDL_WORD_BITS = 30;
    localparam int ADDL_PAYLOAD_BITS = 24;
    localparam int CONTENT_ID_BITS = 5;
    localparam int CRC_BITS = 5;
    localparam logic [4:0] CRC_POLY = 5'h0b;
    // content identifiers sent with each word
    localparam logic [4:0] ID_NONE = 5'h00;
    localparam logic [4:0] ID_POS2 = 5'h01;
    localparam logic [4:0] ID_PARAM = 5'h02;
    localparam logic [4:0] ID_ACK = 5'h03;
    localparam logic [4:0] ID_SENSOR = 5'h04;
    localparam logic [4:0] ID_ERRSRC = 5'h05;
    // memory range select codes
    localparam logic [7:0] SEL_DESELECT = 8'h00;
    localparam logic [7:0] SEL_MANUF = 8'ha1;
    localparam logic [7:0] SEL_OEM = 8'ha3;
    localparam logic [7:0] SEL_OPPARAM = 8'ha5;
    localparam logic [7:0] SEL_OPSTATUS = 8'ha7;
    localparam logic [7:0] SEL_POS2 = 8'h42;
    localparam logic [7:0] SEL_SENSOR = 8'h43;
    localparam logic [7:0] SEL_ACK = 8'h44;
    localparam logic [7:0] SEL_ERRSRC = 8'h59;
    // memory areas
    localparam logic [1:0] AREA_MANUF = 2'h0;
    localparam logic [1:0] AREA_OEM = 2'h1;
    localparam logic [1:0] AREA_OPPARAM = 2'h2;
    localparam logic [1:0] AREA_OPSTATUS = 2'h3;
    // operating status words and the manufacturer area type word
    localparam logic [5:0] WORD_PROTECT = 6'h00;
    localparam logic [5:0] WORD_ERRSRC = 6'h01;
    localparam logic [5:0] WORD_TYPE = 6'h0e;
    localparam int PROT_OEM_BIT = 0;
    localparam int PROT_OPPARAM_BIT = 1;
    localparam int SENSOR_ADDR_BITS = 4;
    // encoder types
    localparam logic [15:0] linear_type = 16'h0000;
    localparam logic [15:0] singleturn_type = 16'h0001;
    localparam logic [15:0] multiturn_type = 16'h0002;
    localparam logic [15:0] incremental_linear_type = 16'h0003;
    localparam logic [15:0] incremental_rotary_type = 16'h0004;
    localparam logic [15:0] touch_probe_type = 16'h0005;
    // access time
    localparam real CLK_MHZ = 125.0;
    localparam real ACCESS_TIME_MS = 12.0;
    localparam int ACCESS_CYCLES = int'(ACCESS_TIME_MS * 1000.0 * CLK_MHZ);
endpackage

// [design/param_memory.sv]
`timescale 1ns/1ps
`default_nettype none
module param_memory #(
    parameter int ADDR_BITS = 8,
    parameter int DATA_BITS = 16
) (
    input wire logic mclk,
    input wire logic writeEn,
    input wire logic [ADDR_BITS-1:0] addr,
    input wire logic [DATA_BITS-1:0] writeData,
    output logic [DATA_BITS-1:0] readData
);
    logic [DATA_BITS-1:0] mem [0:(1<<ADDR_BITS)-1];
    // registered read keeps the read path timing clean
    always_ff @(posedge mclk) begin
        if (writeEn) begin
            mem[addr] <= writeData;
        end
        readData <= mem[addr];
    end
endmodule
`default_nettype wire

// [tb/link_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module link_master_model (
    input wire logic frameReq,
    output logic linkClk
);
    // link clock rests high between frames, one rising edge per frame
    // edges are placed off the system clock edges
    initial begin
        linkClk = 1'b1;
        forever begin
            @(posedge frameReq);
            #2;
            linkClk = 1'b0;
            #32;
            linkClk = 1'b1;
        end
    end
endmodule
`default_nettype wire

// [tb/encoder_addl_data_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module encoder_addl_data_tb_top;
    localparam int WAIT = 10;
    localparam logic [23:0] POS2_VALUE = 24'h0a1b2c;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic linkClk;
    logic frameReq = 1'b0;
    logic selValid = 1'b0;
    logic [7:0] selCode = 8'h00;
    logic accValid = 1'b0;
    logic accWrite = 1'b0;
    logic [5:0] accAddr = 6'h00;
    logic [15:0] accData = 16'h0000;
    logic [15:0] errorSources = 16'ha5c3;
    logic busy, readValid, addlWordValid, referenceDone, initPulse;
    logic [15:0] readData;
    logic [29:0] addlWord;
    logic [3:0] sensorAddr;
    logic [1:0] protectStatus;
    logic absRefDone;
    logic [29:0] absWord;
    int err_count = 0;
    int num_checks = 0;

    always #4 mclk = ~mclk;

    link_master_model link_u (.frameReq(frameReq), .linkClk(linkClk));

    encoder_addl_data #(.ACCESS_WAIT(WAIT)) dut_u (
        .mclk(mclk), .resetn(resetn), .linkClk(linkClk), .selValid(selValid),
        .memory_range_select_code(selCode), .accValid(accValid), .accWrite(accWrite),
        .accAddr(accAddr), .accData(accData), .pos2Abs(POS2_VALUE),
        .sensorValue(24'h012345), .errorSources(errorSources), .referenceIn(1'b0),
        .initDone(1'b0), .busy(busy), .readData(readData), .readValid(readValid),
        .addlWord(addlWord), .addlWordValid(addlWordValid), .sensorAddr(sensorAddr),
        .reference_done_bit(referenceDone), .protectStatus(protectStatus),
        .initPulse(initPulse)
    );

    encoder_addl_data #(.ACCESS_WAIT(WAIT), .ABSOLUTE(1'b1)) dut_abs_u (
        .mclk(mclk), .resetn(resetn), .linkClk(linkClk), .selValid(selValid),
        .memory_range_select_code(selCode), .accValid(accValid), .accWrite(accWrite),
        .accAddr(accAddr), .accData(accData), .pos2Abs(POS2_VALUE),
        .sensorValue(24'h012345), .errorSources(errorSources), .referenceIn(1'b0),
        .initDone(1'b0), .busy(), .readData(), .readValid(),
        .addlWord(absWord), .addlWordValid(), .sensorAddr(),
        .reference_done_bit(absRefDone), .protectStatus(),
        .initPulse()
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic select(input logic [7:0] code);
        @(posedge mclk);
        selValid <= 1'b1;
        selCode <= code;
        @(posedge mclk);
        selValid <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] d,
                          output logic [15:0] rd);
        int n;
        @(posedge mclk);
        accValid <= 1'b1;
        accWrite <= wr;
        accAddr <= a;
        accData <= d;
        @(posedge mclk);
        accValid <= 1'b0;
        #1;
        chk(32'(busy), 32'h1);
        n = 0;
        while (busy === 1'b1 && n < WAIT + 5) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(32'(n), 32'(WAIT));
        if (!wr) begin
            chk(32'(readValid), 32'h1);
        end
        rd = readData;
    endtask

    task automatic frame(output logic [29:0] w);
        int n;
        @(posedge mclk);
        frameReq <= 1'b1;
        @(posedge mclk);
        frameReq <= 1'b0;
        n = 0;
        while (addlWordValid !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(32'(n < 20), 32'h1);
        w = addlWord;
    endtask

    task automatic t_reset();
        #1;
        chk(32'(busy), 32'h0);
        chk(32'(addlWordValid), 32'h0);
        chk(32'(referenceDone), 32'h0);
        chk(32'(absRefDone), 32'h1);
    endtask

    task automatic t_param();
        logic [15:0] rd;
        select(enc_addl_pkg::SEL_MANUF);
        access(1'b0, enc_addl_pkg::WORD_TYPE, 16'h0000, rd);
        chk(32'(rd), 32'(enc_addl_pkg::incremental_rotary_type));
        access(1'b1, enc_addl_pkg::WORD_TYPE, 16'hffff, rd);
        access(1'b0, enc_addl_pkg::WORD_TYPE, 16'h0000, rd);
        chk(32'(rd), 32'(enc_addl_pkg::incremental_rotary_type));
        select(enc_addl_pkg::SEL_OEM);
        access(1'b1, 6'h05, 16'h1234, rd);
        access(1'b0, 6'h05, 16'h0000, rd);
        chk(32'(rd), 32'h1234);
    endtask

    task automatic t_protect();
        logic [15:0] rd;
        select(enc_addl_pkg::SEL_OPSTATUS);
        access(1'b1, enc_addl_pkg::WORD_PROTECT, 16'h0003, rd);
        chk(32'(protectStatus), 32'h3);
        access(1'b1, enc_addl_pkg::WORD_PROTECT, 16'h0004, rd);
        chk(32'(initPulse), 32'h1);
        chk(32'(protectStatus), 32'h3);
        access(1'b0, enc_addl_pkg::WORD_PROTECT, 16'h0000, rd);
        chk(32'(rd), 32'h0003);
        access(1'b0, enc_addl_pkg::WORD_ERRSRC, 16'h0000, rd);
        chk(32'(rd), 32'(errorSources));
        select(enc_addl_pkg::SEL_OEM);
        access(1'b1, 6'h05, 16'h5678, rd);
        access(1'b0, 6'h05, 16'h0000, rd);
        chk(32'(rd), 32'h1234);
    endtask

    task automatic t_content();
        logic [7:0] codes[4];
        logic [4:0] ids[4];
        logic [29:0] w;
        codes = '{enc_addl_pkg::SEL_POS2, enc_addl_pkg::SEL_ACK,
                  enc_addl_pkg::SEL_ERRSRC, enc_addl_pkg::SEL_MANUF};
        ids = '{enc_addl_pkg::ID_POS2, enc_addl_pkg::ID_ACK,
                enc_addl_pkg::ID_ERRSRC, enc_addl_pkg::ID_PARAM};
        for (int i = 0; i < 4; i++) begin
            select(codes[i]);
            repeat (2) begin
                frame(w);
                chk(32'(w[29]), 32'h0);
                chk(32'(w[28:24]), 32'(ids[i]));
                if (i == 0) begin
                    chk(32'(w[23:5]), 32'h0);
                    chk(32'(absWord[23:5]), 32'(POS2_VALUE[23:5]));
                end
            end
        end
    endtask

    task automatic t_sensor();
        logic [29:0] w;
        logic [3:0] a;
        select(enc_addl_pkg::SEL_SENSOR);
        frame(w);
        a = sensorAddr;
        chk(32'(w[28:24]), 32'(enc_addl_pkg::ID_SENSOR));
        frame(w);
        chk(32'(sensorAddr), 32'(a + 4'h1));
        chk(32'(w[23:20]), 32'(a));
    endtask

    task automatic t_deselect();
        int seen;
        select(enc_addl_pkg::SEL_DESELECT);
        seen = 0;
        @(posedge mclk);
        frameReq <= 1'b1;
        @(posedge mclk);
        frameReq <= 1'b0;
        repeat (20) begin
            @(posedge mclk);
            #1;
            if (addlWordValid === 1'b1) begin
                seen++;
            end
        end
        chk(32'(seen), 32'h0);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_param();
        t_protect();
        t_content();
        t_sensor();
        t_deselect();
        stop_test();
    end

    initial begin
        #300000;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
